/* File: core/nv_host_ctrl.sv */
`timescale 1ns/1ps
module nv_host_ctrl
  import nv_host_pkg::*;
#(
  parameter int SAVE_CYCLES = SAVE_CYC,
  parameter int LOAD_CYCLES = LOAD_CYC
)(
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              req_valid,
  input  req_s                   req,
  output logic                   req_ready,
  output logic                   rdata_valid,
  output logic [DATA_W-1:0]      rdata,
  output logic                   busy,
  input  wire logic              supply_low,
  output ctrl_pins_s             pins,
  output logic [ADDR_W-1:0]      address_pins,
  output logic [DATA_W-1:0]      data_pins_o,
  output logic                   data_pins_oe,
  input  wire logic [DATA_W-1:0] data_pins_i
);

  // gray order along idle -> setup -> hold -> release -> busy
  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_IDLE    = 3'b001,
    ST_SETUP   = 3'b011,
    ST_HOLD    = 3'b010,
    ST_RELEASE = 3'b110,
    ST_BUSY    = 3'b111
  } state_e;

  // --------------------------------------------------------------
  // pin synchroniser for supply flag
  // --------------------------------------------------------------
  logic [2:0] low_sync_q;
  logic [2:0] low_sync_d;
  logic       low_q;
  logic       low_d;

  always_comb begin
    low_sync_d = {low_sync_q[1:0], supply_low};
    low_d      = (low_sync_q[2] == low_sync_q[1]) ? low_sync_q[2] : low_q;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      low_sync_q <= 3'h7;
      low_q      <= 1'b1;
    end else begin
      low_sync_q <= low_sync_d;
      low_q      <= low_d;
    end
  end

  // data bus samples: pins are async to our clock
  logic [DATA_W-1:0] dq_s1_q;
  logic [DATA_W-1:0] dq_s2_q;
  logic [DATA_W-1:0] dq_s3_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      dq_s3_q <= '0;
    end else begin
      dq_s1_q <= data_pins_i;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
    end
  end

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  state_e             state_q;
  state_e             state_d;
  req_s               cur_q;
  req_s               cur_d;
  ctrl_pins_s         pins_q;
  ctrl_pins_s         pins_d;
  logic               oe_q;
  logic               oe_d;
  logic [DATA_W-1:0]  rdata_q;
  logic [DATA_W-1:0]  rdata_d;
  logic               rvalid_q;
  logic               rvalid_d;
  logic               tload;
  logic [CNT_W-1:0]   tcount;
  logic               tdone;
  logic               t_load_all;
  logic [CNT_W-1:0]   t_count_all;

  // power-up load shares the timer with the sequencer
  nv_wait_timer u_timer (
    .clock (clock),
    .reset (reset),
    .load  (t_load_all),
    .count (t_count_all),
    .done  (tdone)
  );

  function automatic logic [CNT_W-1:0] hold_cycles(op_e op);
    case (op)
      OP_READ:  hold_cycles = CNT_W'(ACCESS_CYC + 2);
      OP_WRITE: hold_cycles = CNT_W'(WRITE_CYC);
      default:  hold_cycles = CNT_W'(INIT_CYC);
    endcase
  endfunction

  // a request the host may not issue: store under low supply
  logic take;
  assign take      = (state_q == ST_IDLE) && req_valid;
  assign req_ready = (state_q == ST_IDLE);
  assign busy      = (state_q != ST_IDLE);

  always_comb begin
    state_d  = state_q;
    cur_d    = cur_q;
    pins_d   = pins_q;
    oe_d     = oe_q;
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    tload    = 1'b0;
    tcount   = '0;
    case (state_q)
      ST_POWERUP: begin
        // RULE_14 wait power-up load
        if (tdone) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (take) begin
          cur_d = req;
          // RULE_12 refuse low-voltage store
          if (req.op == OP_STORE && low_q) begin
            cur_d.op = OP_IDLE;
          end
          // RULE_05 strobe set before select falls
          pins_d                 = PINS_IDLE;
          pins_d.write_strobe_n  = (cur_d.op == OP_WRITE || cur_d.op == OP_STORE) ? 1'b0 : 1'b1;
          // RULE_13 enable and output set up first
          pins_d.nonvolatile_enable_n = (cur_d.op == OP_STORE || cur_d.op == OP_RECALL) ? 1'b0 : 1'b1;
          oe_d    = 1'b0;
          state_d = (cur_d.op == OP_IDLE) ? ST_IDLE : ST_SETUP;
        end
      end
      ST_SETUP: begin
        // RULE_01 RULE_02 RULE_03 RULE_04 mode decode
        pins_d  = pins_for(cur_q.op);
        // RULE_08 drive bus only on writes
        oe_d    = (cur_q.op == OP_WRITE);
        tload   = 1'b1;
        tcount  = hold_cycles(cur_q.op);
        state_d = ST_HOLD;
      end
      ST_HOLD: begin
        if (tdone) begin
          // RULE_07 sample after access time
          if (cur_q.op == OP_READ) begin
            rdata_d  = dq_s3_q;
            rvalid_d = 1'b1;
          end
          // RULE_10 end initiation via select
          pins_d.chip_select_n = 1'b1;
          state_d = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        // RULE_06 enable back high after access
        pins_d = PINS_IDLE;
        oe_d   = 1'b0;
        if (cur_q.op == OP_STORE || cur_q.op == OP_RECALL) begin
          // RULE_09 RULE_15 wait operation duration
          tload   = 1'b1;
          tcount  = (cur_q.op == OP_STORE) ? CNT_W'(SAVE_CYCLES) : CNT_W'(RECALL_CYC);
          state_d = ST_BUSY;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_BUSY: begin
        // RULE_11 pins idle until store ends
        if (tdone) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        pins_d  = PINS_IDLE;
        oe_d    = 1'b0;
      end
    endcase
  end

  // power-up wait loads the timer once after reset
  logic pwr_load_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q    <= ST_POWERUP;
      cur_q      <= '0;
      pins_q     <= PINS_IDLE;
      oe_q       <= 1'b0;
      rdata_q    <= '0;
      rvalid_q   <= 1'b0;
      pwr_load_q <= 1'b1;
    end else begin
      state_q    <= state_d;
      cur_q      <= cur_d;
      pins_q     <= pins_d;
      oe_q       <= oe_d;
      rdata_q    <= rdata_d;
      rvalid_q   <= rvalid_d;
      pwr_load_q <= 1'b0;
    end
  end

  assign t_load_all  = tload | pwr_load_q;
  assign t_count_all = pwr_load_q ? CNT_W'(LOAD_CYCLES) : tcount;

  assign pins         = pins_q;
  assign address_pins = cur_q.addr;
  assign data_pins_o  = cur_q.wdata;
  assign data_pins_oe = oe_q;
  assign rdata        = rdata_q;
  assign rdata_valid  = rvalid_q;

endmodule

/* File: core/nv_host_pkg.sv */
// Operation
// RULE_01: read when select and output enable low
// RULE_02: write when select and strobe low
// RULE_03: store when enable, select, strobe low
// RULE_04: recall when select, output, enable low
// RULE_05: host holds strobe fixed per access
// RULE_06: host keeps enable high for accesses
// RULE_07: read data follows address continuously
// RULE_08: strobe low at select keeps outputs off
// RULE_09: store self-completes within store duration
// RULE_10: host ends initiation by releasing one pin
// RULE_11: store end shown by outputs driving
// RULE_12: no store below low-voltage level
// RULE_13: host avoids recall pattern during store
// RULE_14: power-up recall finishes within load duration
// RULE_15: busy states ignore pins until done
package nv_host_pkg;

  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;

  localparam int CLK_PERIOD_NS       = 50;
  localparam int INIT_TIME_NS        = 20;
  localparam int RECALL_TIME_US      = 20;
  localparam int SAVE_DURATION_MS    = 10;
  localparam int POWERUP_LOAD_US     = 550;
  localparam int ACCESS_TIME_NS      = 55;
  localparam int WRITE_PULSE_NS      = 45;

  // least times round up, at least one cycle
  localparam int INIT_CYC   = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC  = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // waits on device maxima, host must wait the full figure
  localparam int RECALL_CYC = (RECALL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAVE_CYC   = (SAVE_DURATION_MS * 1000000) / CLK_PERIOD_NS;
  localparam int LOAD_CYC   = (POWERUP_LOAD_US * 1000) / CLK_PERIOD_NS;

  localparam int CNT_W = 24;

  typedef enum logic [2:0] {
    OP_IDLE   = 3'h0,
    OP_READ   = 3'h1,
    OP_WRITE  = 3'h2,
    OP_STORE  = 3'h3,
    OP_RECALL = 3'h4
  } op_e;

  // active-low control pins, all driven by the host
  typedef struct packed {
    logic chip_select_n;
    logic write_strobe_n;
    logic output_enable_n;
    logic nonvolatile_enable_n;
  } ctrl_pins_s;

  typedef struct packed {
    op_e               op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_s;

  localparam ctrl_pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1};

  function automatic ctrl_pins_s pins_for(op_e op);
    case (op)
      OP_READ:   pins_for = '{1'b0, 1'b1, 1'b0, 1'b1};
      OP_WRITE:  pins_for = '{1'b0, 1'b0, 1'b1, 1'b1};
      OP_STORE:  pins_for = '{1'b0, 1'b0, 1'b1, 1'b0};
      OP_RECALL: pins_for = '{1'b0, 1'b1, 1'b0, 1'b0};
      default:   pins_for = PINS_IDLE;
    endcase
  endfunction

endpackage

/* File: core/nv_wait_timer.sv */
`timescale 1ns/1ps
module nv_wait_timer
  import nv_host_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] count,
  output logic                  done
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = count;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - CNT_W'(1);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == '0) && !load;

endmodule

/* File: tb/nv_dev_model.sv */
`timescale 1ns/1ps
module nv_dev_model
  import nv_host_pkg::*;
#(
  parameter int SAVE_DUR   = 15,
  parameter int LOAD_DUR   = 8,
  parameter int RECALL_DUR = 300
)(
  input  wire logic              clock,
  input  ctrl_pins_s             pins,
  input  wire logic [ADDR_W-1:0] address_pins,
  input  wire logic [DATA_W-1:0] bus,
  input  wire logic              supply_low,
  output logic [DATA_W-1:0]      q,
  output logic                   q_oe
);
  logic [DATA_W-1:0] nv_q [2**ADDR_W] = '{default: 8'h00};
  // power-up load copies the zeroed shadow
  logic [DATA_W-1:0] mem_q [2**ADDR_W] = '{default: 8'h00};
  ctrl_pins_s        prev_q = PINS_IDLE;
  logic              wfirst_q = 1'b0;
  int                busy_q = LOAD_DUR;
  assign q_oe = busy_q == 0 && pins == 4'b0101 && !wfirst_q;
  assign q = mem_q[address_pins];
  always @(posedge clock) begin
    prev_q <= pins;
    if (prev_q.chip_select_n && !pins.chip_select_n) wfirst_q <= !pins.write_strobe_n;
    if (busy_q > 0) busy_q <= busy_q - 1;
    else if (!pins.chip_select_n && !pins.write_strobe_n && pins.nonvolatile_enable_n) mem_q[address_pins] <= bus;
    else if (pins == 4'b0010 && prev_q != 4'b0010 && !supply_low) begin
      nv_q <= mem_q;
      busy_q <= SAVE_DUR;
    end
    else if (pins == 4'b0100 && prev_q != 4'b0100) begin
      mem_q <= nv_q;
      busy_q <= RECALL_DUR;
    end
  end
endmodule

/* File: tb/nv_host_ctrl_props.sv */
`timescale 1ns/1ps
module nv_host_ctrl_props
  import nv_host_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              req_valid,
  input  req_s                   req,
  input  wire logic              req_ready,
  input  wire logic              rdata_valid,
  input  wire logic              busy,
  input  wire logic              supply_low,
  input  ctrl_pins_s             pins,
  input  wire logic [ADDR_W-1:0] address_pins,
  input  wire logic [DATA_W-1:0] data_pins_o,
  input  wire logic              data_pins_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence take(op_e o);
    req_valid && req_ready && req.op == o;
  endsequence
  // five samples cover three sync flops plus the filter flop
  sequence supply_ok;
    (!supply_low) [*5];
  endsequence
  sequence supply_bad;
    supply_low [*5];
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_read_pins: assert property (take(OP_READ) |-> ##2 pins == 4'b0101)
    else $error("read pins wrong");
  a_write_pins: assert property (take(OP_WRITE) |-> ##2 pins == 4'b0011 && data_pins_oe
    && data_pins_o == $past(req.wdata, 2) && address_pins == $past(req.addr, 2))
    else $error("write pins wrong");
  a_store_pins: assert property (supply_ok ##0 take(OP_STORE) |-> ##2 pins == 4'b0010)
    else $error("store pins wrong");
  a_recall_pins: assert property (take(OP_RECALL) |-> ##2 pins == 4'b0100)
    else $error("recall pins wrong");
  a_low_no_store: assert property (supply_bad ##0 take(OP_STORE) |-> ##1 pins.nonvolatile_enable_n [*2])
    else $error("store began at low supply");
  a_store_wait: assert property (supply_ok ##0 take(OP_STORE) |-> ##1 busy [*8])
    else $error("store wait cut short");
  a_read_answer: assert property (take(OP_READ) |-> ##[3:12] rdata_valid)
    else $error("read data late");
  a_bus_released: assert property (!pins.chip_select_n && pins.write_strobe_n |-> !data_pins_oe)
    else $error("host drives bus in read");
  a_ready_idle: assert property (req_ready |-> !busy && pins == 4'b1111)
    else $error("ready while not idle");
  a_powerup_wait: assert property ($fell(reset) |-> !req_ready [*8])
    else $error("ready during power-up load");
endmodule

bind nv_host_ctrl nv_host_ctrl_props i_nv_host_ctrl_props (.clock, .reset, .req_valid, .req, .req_ready,
  .rdata_valid, .busy, .supply_low, .pins, .address_pins, .data_pins_o, .data_pins_oe);

/* File: tb/nv_host_ctrl_tb_top.sv */
`timescale 1ns/1ps
module nv_host_ctrl_tb_top;
  import nv_host_pkg::*;
  logic              clock = 1'b0;
  logic              reset = 1'b1;
  logic              req_valid = 1'b0;
  logic              supply_low = 1'b0;
  req_s              req = '0;
  logic              req_ready, rdata_valid, busy, data_pins_oe, dev_oe;
  logic [DATA_W-1:0] rdata, data_pins_o, dev_q, data_pins_i;
  logic [DATA_W-1:0] bus_q = 8'h00;
  ctrl_pins_s        pins;
  logic [ADDR_W-1:0] address_pins;
  int                fails = 0;
  int                check_count = 0;
  int                seed = 32'h461e;
  logic [7:0]        sram_m [int];
  logic [7:0]        nv_m [int];
  always #25 clock = ~clock;
  // released bus shows the inverse of its last level
  always @(posedge clock) bus_q <= data_pins_i;
  assign data_pins_i = data_pins_oe ? data_pins_o : dev_oe ? dev_q : ~bus_q;
  nv_host_ctrl #(.SAVE_CYCLES(20), .LOAD_CYCLES(10)) i_nv_host_ctrl (.clock, .reset, .req_valid, .req,
    .req_ready, .rdata_valid, .rdata, .busy, .supply_low, .pins, .address_pins, .data_pins_o,
    .data_pins_oe, .data_pins_i);
  nv_dev_model i_nv_dev_model (.clock, .pins, .address_pins, .bus(data_pins_i), .supply_low,
    .q(dev_q), .q_oe(dev_oe));
  function automatic logic [7:0] rd_exp(int a);
    return sram_m.exists(a) ? sram_m[a] : 8'h00;
  endfunction
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t read %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic go(op_e op, int a, logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 2000) begin
      @(posedge clock);
      #1 n++;
    end
    if (n >= 2000) fails++;
    req_valid = 1'b1;
    req = '{op, a[12:0], d};
    @(posedge clock);
    #1 req_valid = 1'b0;
    // a dropped request leaves ready high: let an edge pass
    @(posedge clock);
    #1;
    case (op)
      OP_WRITE:  sram_m[a] = d;
      OP_STORE:  if (!supply_low) nv_m = sram_m;
      OP_RECALL: sram_m = nv_m;
      default:   ;
    endcase
    n = 0;
    while (op == OP_READ && rdata_valid !== 1'b1 && n < 50) begin
      @(posedge clock);
      #1 n++;
    end
    if (op == OP_READ) check(rdata, rd_exp(a));
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    int a;
    repeat (3) @(posedge clock);
    #1 reset = 1'b0;
    go(OP_WRITE, 13'h1fff, 8'ha5);
    go(OP_READ, 13'h1fff, 8'h00);
    for (int i = 0; i < 40; i++) begin
      a = $random(seed) & 7;
      go((($random(seed) & 1) != 0) ? OP_READ : OP_WRITE, a, 8'($random(seed)));
    end
    go(OP_STORE, 0, 8'h00);
    go(OP_WRITE, 3, 8'h3c);
    go(OP_READ, 3, 8'h00);
    go(OP_RECALL, 0, 8'h00);
    for (int i = 0; i < 8; i++) go(OP_READ, i, 8'h00);
    supply_low = 1'b1;
    repeat (5) @(posedge clock);
    #1 go(OP_WRITE, 3, 8'h5a);
    go(OP_STORE, 0, 8'h00);
    supply_low = 1'b0;
    go(OP_RECALL, 0, 8'h00);
    go(OP_READ, 3, 8'h00);
    close_out();
  end
  initial begin
    #(50 * 20000);
    fails++;
    close_out();
  end
endmodule
